/* File: verilog/elc_pkg.sv */
// Constants and carrier types for the added-lane and sync-header configuration block.
// Assumes a single 40 MHz clock and a plain strobe register port from host software.
// Notes on behaviour
// - Link A mask bits 7:1 clock lanes A1-A7
// - Link B mask bits 7:1 clock lanes B1-B7
// - Bit 0 adds serializers, else clocks only
// - Added lanes follow format rate and test mode
// - Added-only lanes send octet ramp on test 0/5
// - Channel power-down keeps added lanes inactive
// - Serializer n clocked only if lanes below enabled
// - Sync-header select bits 1:0, 64b/66b only
// - Code 0 CRC-12, code 2 FEC, others reserved
// - All sync-word command fields driven zero
// - Both channels down powers whole link subsystem down
package elc_pkg;

    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam int          LANES           = 8;
    localparam int          TEST_W          = 4;

    localparam logic [11:0] OFS_EXTRA_A     = 12'h20A;
    localparam logic [11:0] OFS_EXTRA_B     = 12'h20B;
    localparam logic [11:0] OFS_SH_MODE     = 12'h20F;

    localparam logic [7:0]  RST_EXTRA       = 8'h00;
    localparam logic [7:0]  RST_SH_MODE     = 8'h00;

    localparam int          SER_ON_BIT      = 0;
    localparam int          MASK_LSB        = 1;
    localparam int          MASK_MSB        = 7;
    localparam int          SH_LSB          = 0;
    localparam int          SH_MSB          = 1;

    localparam logic [1:0]  SH_CRC12        = 2'h0;
    localparam logic [1:0]  SH_FEC          = 2'h2;

    localparam logic [3:0]  TEST_NONE       = 4'h0;
    localparam logic [3:0]  TEST_RAMP       = 4'h4;
    localparam logic [3:0]  TEST_ALT        = 4'h5;

    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

    typedef enum logic [1:0] {
        ELC_SH_NONE  = 2'b00,
        ELC_SH_CRC12 = 2'b01,
        ELC_SH_FEC   = 2'b10
    } elc_sh_e;

    // Per-link lane controls towards the serial output path
    typedef struct packed {
        logic [7:0] clk_en;
        logic [7:0] ser_en;
        logic [7:0] ramp_force;
        logic [3:0] test_sel;
    } elc_lane_s;

    typedef struct packed {
        logic [7:0] format_lanes;
        logic       pd;
    } elc_link_in_s;

endpackage

/* File: verilog/elc_cfg.sv */
// Added-lane enables and sync-header content selection for serial links A and B.
// Assumes format lanes, test selection and power-down come from logic on the same clock.
//
// Chosen here: the plain strobed port.
module elc_cfg (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic [elc_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [elc_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [elc_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        serial_link_enable,
    input  wire logic                        format_is_64b66b,
    input  wire logic [elc_pkg::TEST_W-1:0]  lane_test_pattern_select,
    input  wire elc_pkg::elc_link_in_s       link_a_in,
    input  wire elc_pkg::elc_link_in_s       link_b_in,
    output elc_pkg::elc_lane_s               link_a_lanes,
    output elc_pkg::elc_lane_s               link_b_lanes,
    output elc_pkg::elc_sh_e                 sync_header_content,
    output logic      [3:0]                  sync_cmd_field,
    output logic                             subsystem_power_down
);

    logic [7:0]            extra_a_q;
    logic [7:0]            extra_b_q;
    logic [7:0]            sh_mode_q;
    elc_pkg::elc_lane_s    lane_a_d;
    elc_pkg::elc_lane_s    lane_b_d;
    elc_pkg::elc_sh_e      sh_d;
    logic                  all_down;

    ////////////////////////////////////////////////////////////////////////////
    // Register writes; ordering against the link enable is the host's job

    always_ff @(posedge clk) begin
        if (!nrst) begin
            extra_a_q <= elc_pkg::RST_EXTRA;
            extra_b_q <= elc_pkg::RST_EXTRA;
            sh_mode_q <= elc_pkg::RST_SH_MODE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                elc_pkg::OFS_EXTRA_A: extra_a_q <= reg_wdata;
                elc_pkg::OFS_EXTRA_B: extra_b_q <= reg_wdata;
                elc_pkg::OFS_SH_MODE: sh_mode_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= elc_pkg::RD_UNMAPPED;
        end else if (reg_rd) begin
            unique case (reg_addr)
                elc_pkg::OFS_EXTRA_A: reg_rdata <= extra_a_q;
                elc_pkg::OFS_EXTRA_B: reg_rdata <= extra_b_q;
                elc_pkg::OFS_SH_MODE: reg_rdata <= sh_mode_q;
                default:              reg_rdata <= elc_pkg::RD_UNMAPPED;
            endcase
        end else begin
            reg_rdata <= elc_pkg::RD_UNMAPPED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lane computation, shared by both links

    function automatic elc_pkg::elc_lane_s lanes_for(
        input logic [7:0]                extra,
        input elc_pkg::elc_link_in_s     li,
        input logic                      down,
        input logic [elc_pkg::TEST_W-1:0] tsel
    );
        logic [7:0]       added;
        logic [7:0]       active;
        logic [7:0]       chain;
        elc_pkg::elc_lane_s r;
        added  = {extra[elc_pkg::MASK_MSB:elc_pkg::MASK_LSB], 1'b0};
        active = li.format_lanes | added;
        if (li.pd || down) begin
            active = 8'h00;
        end
        chain = 8'h00;
        chain[0] = active[0];
        for (int n = 1; n < elc_pkg::LANES; n++) begin
            chain[n] = chain[n-1] & active[n];
        end
        r.clk_en = active;
        // Format lanes serialize when they and all lanes below are active; added ones only with bit 0 set
        r.ser_en = chain & (li.format_lanes | (extra[elc_pkg::SER_ON_BIT] ? added : 8'h00));
        if ((tsel == elc_pkg::TEST_NONE) || (tsel == elc_pkg::TEST_ALT)) begin
            r.ramp_force = active & ~li.format_lanes;
        end else begin
            r.ramp_force = 8'h00;
        end
        r.test_sel = tsel;
        return r;
    endfunction

    always_comb begin
        all_down = link_a_in.pd & link_b_in.pd;
        lane_a_d = lanes_for(extra_a_q, link_a_in, all_down, lane_test_pattern_select);
        lane_b_d = lanes_for(extra_b_q, link_b_in, all_down, lane_test_pattern_select);
        if (!format_is_64b66b || !serial_link_enable) begin
            sh_d = elc_pkg::ELC_SH_NONE;
        end else if (sh_mode_q[elc_pkg::SH_MSB:elc_pkg::SH_LSB] == elc_pkg::SH_FEC) begin
            sh_d = elc_pkg::ELC_SH_FEC;
        end else begin
            // Reserved codes fall back to the reset behaviour
            sh_d = elc_pkg::ELC_SH_CRC12;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge clk) begin
        if (!nrst) begin
            link_a_lanes         <= '0;
            link_b_lanes         <= '0;
            subsystem_power_down <= 1'b0;
        end else begin
            link_a_lanes         <= lane_a_d;
            link_b_lanes         <= lane_b_d;
            subsystem_power_down <= all_down;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_header_content <= elc_pkg::ELC_SH_NONE;
            sync_cmd_field      <= 4'h0;
        end else begin
            sync_header_content <= sh_d;
            sync_cmd_field      <= 4'h0;
        end
    end

endmodule

/* File: tb/elc_cfg_props.sv */
// Port checker for elc_cfg.
// Bound from the bench top; sees ports only.
module elc_cfg_props (
    input wire logic                  clk,
    input wire logic                  nrst,
    input wire logic                  serial_link_enable,
    input wire logic                  format_is_64b66b,
    input wire logic [3:0]            lane_test_pattern_select,
    input wire elc_pkg::elc_link_in_s link_a_in,
    input wire elc_pkg::elc_link_in_s link_b_in,
    input wire elc_pkg::elc_lane_s    link_a_lanes,
    input wire elc_pkg::elc_sh_e      sync_header_content,
    input wire logic [3:0]            sync_cmd_field,
    input wire logic                  subsystem_power_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_cmd_idle: assert property (sync_cmd_field == 4'h0)
        else $error("cmd field set");
    a_pd_both: assert property ($past(nrst) |-> subsystem_power_down == $past(link_a_in.pd && link_b_in.pd))
        else $error("pd wrong");
    a_pd_off: assert property ($past(nrst) && $past(link_a_in.pd) |-> link_a_lanes.clk_en == 8'h00)
        else $error("lane on in pd");
    a_fmt_kept: assert property ($past(nrst) && !$past(link_a_in.pd) |->
        (link_a_lanes.clk_en & $past(link_a_in.format_lanes)) == $past(link_a_in.format_lanes)) else $error("fmt lost");
    // Trailing-ones mask of clk_en bounds the serializers
    a_ser_chain: assert property ((link_a_lanes.ser_en & ~(link_a_lanes.clk_en & ~(link_a_lanes.clk_en + 8'h01))) == 8'h00)
        else $error("ser chain");
    a_ramp_only: assert property (link_a_lanes.ramp_force != 8'h00 |-> $past(lane_test_pattern_select) inside {4'h0, 4'h5})
        else $error("ramp sel");
    a_test_pass: assert property ($past(nrst) |-> link_a_lanes.test_sel == $past(lane_test_pattern_select))
        else $error("test sel");
    a_sh_none: assert property ($past(nrst) && !$past(format_is_64b66b && serial_link_enable) |->
        sync_header_content == elc_pkg::ELC_SH_NONE) else $error("sh not none");
endmodule

/* File: tb/elc_rx_model.sv */
// Far-end lane receiver stand-in.
// Reports lanes whose serializer runs with its clock.
module elc_rx_model (
    input wire elc_pkg::elc_lane_s lanes_a,
    output logic [7:0]             seen_a
);
    assign seen_a = lanes_a.ser_en & lanes_a.clk_en;
endmodule

/* File: tb/elc_cfg_tb.sv */
// Bench for elc_cfg, far end elc_rx_model.
// Registers written only while the link is disabled.
module elc_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, len = 1'b0, f66 = 1'b0, spd;
    logic [11:0]           addr = 12'h000;
    logic [7:0]            wd = 8'h00, rdata, seen;
    logic [3:0]            tsel = 4'h0, cmd;
    elc_pkg::elc_link_in_s in_a = '0, in_b = '0;
    elc_pkg::elc_lane_s    oa, ob;
    elc_pkg::elc_sh_e      sh;
    int                    error_cnt = 0, checked = 0;
    elc_cfg elc_cfg_inst (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata), .serial_link_enable(len), .format_is_64b66b(f66), .lane_test_pattern_select(tsel),
        .link_a_in(in_a), .link_b_in(in_b), .link_a_lanes(oa), .link_b_lanes(ob), .sync_header_content(sh),
        .sync_cmd_field(cmd), .subsystem_power_down(spd));
    elc_rx_model elc_rx_model_inst (.lanes_a(oa), .seen_a(seen));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        settle();
    endtask
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
    endtask
    task automatic t_lanes();
        @(posedge clk);
        len <= 1'b0;
        in_a.format_lanes <= 8'h01;
        in_b.format_lanes <= 8'h01;
        wr_reg(12'h20A, 8'h03);
        chk(oa.clk_en, 8'h03);
        chk(seen, 8'h03);
        chk(oa.ramp_force, 8'h02);
        rd_reg(12'h20A);
        chk(rdata, 8'h03);
        wr_reg(12'h20A, 8'h02);
        chk(oa.ser_en, 8'h01);
        wr_reg(12'h20B, 8'h09);
        chk(ob.clk_en, 8'h09);
        chk(ob.ser_en, 8'h01);
        @(posedge clk);
        tsel <= 4'h4;
        settle();
        chk(ob.ramp_force, 8'h00);
        chk(ob.test_sel, 8'h04);
        @(posedge clk);
        tsel <= 4'h5;
        settle();
        chk(oa.ramp_force, 8'h02);
        chk(ob.ramp_force, 8'h08);
    endtask
    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        settle();
        chk(oa.clk_en, 8'h00);
        chk(ob.ser_en, 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        rd_reg(12'h20B);
        chk(rdata, 8'h00);
        settle();
        chk(oa.clk_en, 8'h01);
    endtask
    task automatic t_power();
        @(posedge clk);
        in_a.pd <= 1'b1;
        settle();
        chk(oa.clk_en, 8'h00);
        chk(spd, 8'h00);
        @(posedge clk);
        in_b.pd <= 1'b1;
        settle();
        chk(spd, 8'h01);
        chk(ob.clk_en, 8'h00);
    endtask
    task automatic t_sync();
        rd_reg(12'h20F);
        chk(rdata, 8'h00);
        rd_reg(12'h20C);
        chk(rdata, 8'h00);
        wr_reg(12'h20F, 8'hFE);
        @(posedge clk);
        len <= 1'b1;
        f66 <= 1'b1;
        settle();
        chk(sh, elc_pkg::ELC_SH_FEC);
        rd_reg(12'h20F);
        chk(rdata, 8'hFE);
        @(posedge clk);
        len <= 1'b0;
        settle();
        chk(sh, elc_pkg::ELC_SH_NONE);
        wr_reg(12'h20F, 8'h00);
        @(posedge clk);
        len <= 1'b1;
        settle();
        chk(sh, elc_pkg::ELC_SH_CRC12);
        @(posedge clk);
        len <= 1'b0;
        wr_reg(12'h20F, 8'h03);
        @(posedge clk);
        len <= 1'b1;
        settle();
        chk(sh, elc_pkg::ELC_SH_CRC12);
        @(posedge clk);
        f66 <= 1'b0;
        settle();
        chk(sh, elc_pkg::ELC_SH_NONE);
        chk(cmd, 8'h00);
    endtask
    task automatic wrap_up();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_sync();
        t_lanes();
        t_reset();
        t_power();
        wrap_up();
    end
endmodule
bind elc_cfg elc_cfg_props elc_cfg_props_inst (
    .clk                      (clk),
    .nrst                     (nrst),
    .serial_link_enable       (serial_link_enable),
    .format_is_64b66b         (format_is_64b66b),
    .lane_test_pattern_select (lane_test_pattern_select),
    .link_a_in                (link_a_in),
    .link_b_in                (link_b_in),
    .link_a_lanes             (link_a_lanes),
    .sync_header_content      (sync_header_content),
    .sync_cmd_field           (sync_cmd_field),
    .subsystem_power_down     (subsystem_power_down)
);
